// [bench/testbench.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Divider chain bench
// ----------------------------------------------------------------------
module testbench;
  logic                ref_clk;
  logic                nrst;
  logic                int_tick;
  logic                ext_clk_pin;
  rtcd_pkg::rtcd_cfg_t cfg;
  logic [15:0]         hi_w;
  logic [15:0]         lo_w;
  logic [15:0]         pre_w;
  logic [4:0]          req;
  logic                creq;
  logic [4:0]          seen;
  logic                seen_clr;
  int                  fails;
  int                  checked;
  int                  or_bad;

  rtcd_top i_rtcd_top (
    .ref_clk         (ref_clk),
    .nrst            (nrst),
    .int_tick        (int_tick),
    .ext_clk_pin     (ext_clk_pin),
    .cfg             (cfg),
    .count_high_word (hi_w),
    .count_low_word  (lo_w),
    .prescale_timer  (pre_w),
    .stage_req       (req),
    .common_req      (creq)
  );

  // 50 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Collect requests and watch the merged request
  always @(posedge ref_clk)
  begin
    if (!nrst || seen_clr)
      seen <= '0;
    else
      seen <= seen | req;
    if (nrst && (creq !== |req))
      or_bad <= or_bad + 1;
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp,
                       input string msg);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk16

  task automatic chk5(input logic [4:0] got, input logic [4:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t requests %b exp %b", $time, got, exp);
    end
  endtask : chk5

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle

  // Clear the collected requests through the collector itself
  task automatic clr_seen;
    @(posedge ref_clk) seen_clr <= 1'b1;
    @(posedge ref_clk) seen_clr <= 1'b0;
  endtask : clr_seen

  // Burst of internal ticks, then let the chain settle
  task automatic ticks(input int n);
    repeat (n) @(posedge ref_clk) int_tick <= 1'b1;
    @(posedge ref_clk) int_tick <= 1'b0;
    settle(5);
  endtask : ticks

  // Expected prescale value after n steps
  function automatic logic [15:0] pre_step(input logic [15:0] v,
                                           input int n);
    for (int i = 0; i < n; i++)
      v = (v == 16'hFFFF) ? cfg.pre_reload : v + 16'h0001;
    return v;
  endfunction : pre_step

  // Single ticks until the prescaler moves or overflows
  task automatic tick_until(input bit on_req);
    logic [15:0] p0;
    int          k;
    p0 = pre_w;
    for (k = 0; k < 300; k++)
    begin
      ticks(1);
      if (on_req ? seen[0] : (pre_w !== p0))
        break;
    end
    if (k == 300)
    begin
      fails++;
      $display("MISMATCH t=%0t prescale timer never moved", $time);
      test_done();
    end
  endtask : tick_until

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic sc_first;
    clr_seen();
    ticks(65535);
    chk16(pre_w, 16'hFFFF, "prescale up");
    chk5(seen, 5'h00);
    ticks(1);
    chk16(pre_w, 16'hFFFE, "prescale reload");
    chk16(lo_w, 16'h0001, "low word");
    chk5(seen, 5'h01);
  endtask : sc_first

  task automatic sc_div(input logic d32, input logic d8, input int ratio);
    logic [15:0] p;
    @(posedge ref_clk) cfg.div32_en <= d32;
    cfg.div8_en <= d8;
    tick_until(1'b0);
    p = pre_w;
    ticks(ratio - 1);
    chk16(pre_w, p, "divider early");
    ticks(1);
    chk16(pre_w, pre_step(p, 1), "divider step");
  endtask : sc_div

  task automatic sc_cascade(input logic [31:0] val, input logic [31:0] exp,
                            input logic [4:0] rq);
    @(posedge ref_clk) cfg.cnt_load <= 1'b1;
    cfg.cnt_value <= val;
    @(posedge ref_clk) cfg.cnt_load <= 1'b0;
    settle(3);
    chk16(hi_w, val[31:16], "loaded high");
    chk16(lo_w, val[15:0], "loaded low");
    clr_seen();
    tick_until(1'b1);
    settle(6);
    chk16(hi_w, exp[31:16], "cascade high");
    chk16(lo_w, exp[15:0], "cascade low");
    chk5(seen, rq);
  endtask : sc_cascade

  // Pin edges count, internal pulses are ignored
  task automatic sc_ext;
    logic [15:0] p;
    @(posedge ref_clk) cfg.ext_sel <= 1'b1;
    cfg.pre_reload <= 16'h0000;
    settle(2);
    p = pre_w;
    repeat (5)
    begin
      @(posedge ref_clk) ext_clk_pin <= 1'b1;
      int_tick <= 1'b1;
      repeat (2) @(posedge ref_clk);
      int_tick <= 1'b0;
      settle(3);
      @(posedge ref_clk) ext_clk_pin <= 1'b0;
      settle(3);
    end
    settle(6);
    chk16(pre_w, pre_step(p, 5), "pin source");
  endtask : sc_ext

  task automatic sc_zero;
    chk16(pre_w, 16'h0000, "prescale reset");
    chk16(hi_w, 16'h0000, "high reset");
    chk16(lo_w, 16'h0000, "low reset");
    chk5(req, 5'h00);
  endtask : sc_zero

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    nrst = 1'b0;
    int_tick = 1'b0;
    ext_clk_pin = 1'b0;
    cfg = '0;
    cfg.pre_reload = 16'hFFFE;
    cfg.cnt_reload = 32'h0042_0C04;
    seen_clr = 1'b0;
    fails = 0;
    checked = 0;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    settle(2);
    sc_zero();
    sc_first();
    sc_div(1'b1, 1'b0, 32);
    sc_div(1'b0, 1'b1, 8);
    sc_div(1'b1, 1'b1, 256);
    @(posedge ref_clk) cfg.div32_en <= 1'b0;
    cfg.div8_en <= 1'b0;
    sc_cascade(32'hFFBF_FFFF, 32'hFFC2_0C04, 5'h0F);
    sc_cascade(32'hFFFF_FFFF, 32'h0042_0C04, 5'h1F);
    sc_ext();
    chk16(or_bad[15:0], 16'h0000, "merged request");
    @(posedge ref_clk) nrst <= 1'b0;
    settle(2);
    sc_zero();
    test_done();
  end
endmodule : testbench

// [rtl/rtcd_pkg.sv]
package rtcd_pkg;

  // ----------------------------------------------------------------------
  // Chain geometry
  // ----------------------------------------------------------------------
  localparam int PRE_W  = 16;          // Prescale timer width
  localparam int SUB0_W = 10;          // Lowest sub-timer
  localparam int SUB1_W = 6;
  localparam int SUB2_W = 6;
  localparam int SUB3_W = 10;          // Highest sub-timer
  localparam int CNT_W  = 32;          // Whole count
  localparam int DIV_A  = 32;          // First divider ratio
  localparam int DIV_B  = 8;           // Second divider ratio
  localparam int DIV_W  = 5;           // Divide-by-32 counter width
  localparam int STG_N  = 5;           // Number of timer stages

  // ----------------------------------------------------------------------
  // Reset values (power reset only)
  // ----------------------------------------------------------------------
  localparam logic [PRE_W-1:0] PRE_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic             ext_sel;         // 1: external pin clock
    logic             div32_en;        // Divide by 32 in path
    logic             div8_en;         // Divide by 8 in path
    logic [PRE_W-1:0] pre_reload;      // Prescale timer reload
    logic [CNT_W-1:0] cnt_reload;      // Sub-timer reloads, packed
    logic             cnt_load;        // Pulse: load count
    logic [CNT_W-1:0] cnt_value;       // Value for cnt_load
  } rtcd_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } rtcd_state_t;

endpackage : rtcd_pkg

// [rtl/rtcd_stage.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------------------
// Reloadable up-counting stage
// ------------------------------------------------------------------------
module rtcd_stage #(
  parameter int W = 16
) (
  input  wire logic         ref_clk,   // System clock
  input  wire logic         nrst,      // Power reset, active low
  input  wire logic         tick,      // Count enable pulse
  input  wire logic [W-1:0] reload,    // Value taken on overflow
  input  wire logic         load,      // Software load pulse
  input  wire logic [W-1:0] load_val,  // Value for load
  output logic      [W-1:0] cnt,       // Current count
  output logic              ovf        // Overflow pulse to next stage
);

  logic [W-1:0] cnt_r, cnt_nxt;
  logic         ovf_r, ovf_nxt;

  // Count up; on overflow reload and pass one pulse onward
  always_comb
  begin
    cnt_nxt = cnt_r;
    ovf_nxt = 1'b0;
    if (load)
    begin
      cnt_nxt = load_val;
    end
    else if (tick)
    begin
      if (&cnt_r)
      begin
        cnt_nxt = reload;
        ovf_nxt = 1'b1;
      end
      else
      begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  // Registers cleared by power reset only
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r <= '0;
      ovf_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  assign cnt = cnt_r;
  assign ovf = ovf_r;

  // Overflow follows a tick at the all-ones count, with reload
  property p_stage_ovf;
    @(posedge ref_clk) disable iff (!nrst)
      (tick && !load && (&cnt_r)) |=> (ovf_r && cnt_r == $past(reload));
  endproperty
  a_stage_ovf: assert property (p_stage_ovf)
    else $error("stage missed overflow reload");

  property p_stage_up;
    @(posedge ref_clk) disable iff (!nrst)
      (tick && !load && !(&cnt_r)) |=> (cnt_r == $past(cnt_r) + 1'b1);
  endproperty
  a_stage_up: assert property (p_stage_up)
    else $error("stage did not count up");

  property p_stage_hold;
    @(posedge ref_clk) disable iff (!nrst)
      (!tick && !load) |=> ($stable(cnt_r) && !ovf_r);
  endproperty
  a_stage_hold: assert property (p_stage_hold)
    else $error("stage moved without tick");

endmodule : rtcd_stage

// [rtl/rtcd_top.sv]
`timescale 1ns/1ps
module rtcd_top (
  input  wire logic              ref_clk,         // 50 MHz system clock
  input  wire logic              nrst,            // Power reset, active low
  input  wire logic              int_tick,        // Internal source pulse
  input  wire logic              ext_clk_pin,     // External clock pin
  input  wire rtcd_pkg::rtcd_cfg_t cfg,           // Configuration
  output logic [15:0]            count_high_word, // Upper count word
  output logic [15:0]            count_low_word,  // Lower count word
  output logic [15:0]            prescale_timer,  // Prescale timer value
  output logic [rtcd_pkg::STG_N-1:0] stage_req,   // Per-stage requests
  output logic                   common_req       // Merged request
);

  // ----------------------------------------------------------------------
  // Pin synchroniser and edge detect
  // ----------------------------------------------------------------------
  logic [2:0] pin_sync_r, pin_sync_nxt;
  logic       pin_lvl_r, pin_lvl_nxt;
  logic       ext_rise;

  // Three flops; a new level counts once second and third agree
  always_comb
  begin
    pin_sync_nxt = {pin_sync_r[1:0], ext_clk_pin};
    pin_lvl_nxt  = (^pin_sync_r[2:1]) ? pin_lvl_r : pin_sync_r[2];
    ext_rise     = pin_lvl_nxt & ~pin_lvl_r;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_sync_r <= 3'h0;
      pin_lvl_r  <= 1'b0;
    end
    else
    begin
      pin_sync_r <= pin_sync_nxt;
      pin_lvl_r  <= pin_lvl_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Source select and fixed dividers
  // ----------------------------------------------------------------------
  logic                          src_tick;
  logic [rtcd_pkg::DIV_W-1:0]    div32_r, div32_nxt;
  logic [2:0]                    div8_r, div8_nxt;
  logic                          t32, t8;
  rtcd_pkg::rtcd_state_t         st_r, st_nxt;

  assign src_tick = cfg.ext_sel ? ext_rise : int_tick;

  function automatic logic wrap(input logic [4:0] v, input logic [4:0] m);
    wrap = (v == m);
  endfunction : wrap

  // Divider counters; a bypassed divider passes its input straight on
  always_comb
  begin
    div32_nxt = div32_r;
    div8_nxt  = div8_r;
    t32       = src_tick;
    t8        = 1'b0;
    st_nxt    = st_r;
    case (st_r)
      rtcd_pkg::ST_IDLE: if (src_tick) st_nxt = rtcd_pkg::ST_RUN;
      rtcd_pkg::ST_RUN:  st_nxt = rtcd_pkg::ST_RUN;
      default:           st_nxt = rtcd_pkg::ST_IDLE;
    endcase
    if (cfg.div32_en)
    begin
      t32 = 1'b0;
      if (src_tick)
      begin
        t32 = wrap(div32_r, 5'(rtcd_pkg::DIV_A - 1));
        div32_nxt = t32 ? 5'h00 : div32_r + 5'h01;
      end
    end
    t8 = t32;
    if (cfg.div8_en)
    begin
      t8 = 1'b0;
      if (t32)
      begin
        t8 = wrap({2'h0, div8_r}, 5'(rtcd_pkg::DIV_B - 1));
        div8_nxt = t8 ? 3'h0 : div8_r + 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      div32_r <= 5'h00;
      div8_r  <= 3'h0;
      st_r    <= rtcd_pkg::ST_IDLE;
    end
    else
    begin
      div32_r <= div32_nxt;
      div8_r  <= div8_nxt;
      st_r    <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Timer chain
  // ----------------------------------------------------------------------
  logic [15:0] pre_cnt;
  logic [9:0]  s0_cnt, s3_cnt;
  logic [5:0]  s1_cnt, s2_cnt;
  logic [4:0]  ovf;
  logic [31:0] rl, lv;

  assign rl = cfg.cnt_reload;
  assign lv = cfg.cnt_value;

  // Prescale timer then four sub-timers, each fed by the one below
  rtcd_stage #(.W(rtcd_pkg::PRE_W)) u_pre (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .tick     (t8),
    .reload   (cfg.pre_reload),
    .load     (1'b0),
    .load_val (rtcd_pkg::PRE_RST),
    .cnt      (pre_cnt),
    .ovf      (ovf[0])
  );
  rtcd_stage #(.W(rtcd_pkg::SUB0_W)) u_s0 (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .tick     (ovf[0]),
    .reload   (rl[9:0]),
    .load     (cfg.cnt_load),
    .load_val (lv[9:0]),
    .cnt      (s0_cnt),
    .ovf      (ovf[1])
  );
  rtcd_stage #(.W(rtcd_pkg::SUB1_W)) u_s1 (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .tick     (ovf[1]),
    .reload   (rl[15:10]),
    .load     (cfg.cnt_load),
    .load_val (lv[15:10]),
    .cnt      (s1_cnt),
    .ovf      (ovf[2])
  );
  rtcd_stage #(.W(rtcd_pkg::SUB2_W)) u_s2 (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .tick     (ovf[2]),
    .reload   (rl[21:16]),
    .load     (cfg.cnt_load),
    .load_val (lv[21:16]),
    .cnt      (s2_cnt),
    .ovf      (ovf[3])
  );
  rtcd_stage #(.W(rtcd_pkg::SUB3_W)) u_s3 (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .tick     (ovf[3]),
    .reload   (rl[31:22]),
    .load     (cfg.cnt_load),
    .load_val (lv[31:22]),
    .cnt      (s3_cnt),
    .ovf      (ovf[4])
  );

  // ----------------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------------
  logic [31:0] cnt_r, cnt_nxt;
  logic [15:0] pre_r, pre_nxt;
  logic [4:0]  req_r, req_nxt;
  logic        com_r, com_nxt;

  // Register count words, requests and merged request
  always_comb
  begin
    cnt_nxt = {s3_cnt, s2_cnt, s1_cnt, s0_cnt};
    pre_nxt = pre_cnt;
    req_nxt = ovf;
    com_nxt = |ovf;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r <= rtcd_pkg::CNT_RST;
      pre_r <= rtcd_pkg::PRE_RST;
      req_r <= 5'h00;
      com_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      pre_r <= pre_nxt;
      req_r <= req_nxt;
      com_r <= com_nxt;
    end
  end

  assign count_high_word = cnt_r[31:16];
  assign count_low_word  = cnt_r[15:0];
  assign prescale_timer  = pre_r;
  assign stage_req       = req_r;
  assign common_req      = com_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_src_ext;
    @(posedge ref_clk) disable iff (!nrst)
      (cfg.ext_sel && !cfg.div32_en && !cfg.div8_en && ext_rise) |-> t8;
  endproperty
  a_src_ext: assert property (p_src_ext)
    else $error("pin edge not passed on");

  property p_div32;
    @(posedge ref_clk) disable iff (!nrst)
      (cfg.div32_en && src_tick && div32_r != 5'(rtcd_pkg::DIV_A - 1)) |-> !t32;
  endproperty
  a_div32: assert property (p_div32)
    else $error("divide by 32 ticked early");

  property p_div8;
    @(posedge ref_clk) disable iff (!nrst)
      (cfg.div8_en && t32 && div8_r == 3'(rtcd_pkg::DIV_B - 1)) |-> t8;
  endproperty
  a_div8: assert property (p_div8)
    else $error("divide by 8 missed tick");

  property p_pre_feed;
    @(posedge ref_clk) disable iff (!nrst)
      (t8 && pre_cnt == 16'hFFFF) |=> ovf[0] ##1 (s0_cnt != $past(s0_cnt));
  endproperty
  a_pre_feed: assert property (p_pre_feed)
    else $error("prescale timer did not feed chain");

  property p_words;
    @(posedge ref_clk) disable iff (!nrst)
      1'b1 |=> {count_high_word, count_low_word}
               == $past({s3_cnt, s2_cnt, s1_cnt, s0_cnt});
  endproperty
  a_words: assert property (p_words)
    else $error("count words mismatch");

  property p_req;
    @(posedge ref_clk) disable iff (!nrst)
      ovf[2] |=> stage_req[2] && common_req;
  endproperty
  a_req: assert property (p_req)
    else $error("stage request missing");

  property p_common;
    @(posedge ref_clk) disable iff (!nrst)
      common_req |-> (stage_req != 5'h00);
  endproperty
  a_common: assert property (p_common)
    else $error("common request without source");

  property p_up;
    @(posedge ref_clk) disable iff (!nrst)
      (t8 && pre_cnt != 16'hFFFF) |=> ##1 (prescale_timer
        == $past(pre_cnt, 2) + 16'h0001);
  endproperty
  a_up: assert property (p_up)
    else $error("prescale timer not counting up");

  property p_idle_quiet;
    @(posedge ref_clk) disable iff (!nrst)
      (st_r == rtcd_pkg::ST_IDLE) |-> (ovf == 5'h00);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("overflow before first source tick");

  c_ext: cover property (@(posedge ref_clk) cfg.ext_sel && t8);
  c_s0: cover property (@(posedge ref_clk) ovf[1]);
  c_both: cover property (@(posedge ref_clk)
    cfg.div32_en && cfg.div8_en && t8);
  c_load: cover property (@(posedge ref_clk) cfg.cnt_load);

endmodule : rtcd_top
